//--- design/sfu_cycle_mon.sv
/*
  Cycle-time monitor: millisecond timebase, limit register and violation flag.
  Assumes restart and load are one-cycle pulses from the sequencer.
*/
`timescale 1ns/10ps
module sfu_cycle_mon
  import sfu_pkg::*;
#(
  parameter int TICK_CYCLES_P = sfu_pkg::TICK_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  sfu_mon_if.mon    mon
);
  import sfu_pkg::*;

  logic [31:0] tick_ff;
  logic [11:0] ms_ff;
  logic [11:0] limit_ff;
  logic        violation_ff;

  wire         tick    = (tick_ff == 32'(TICK_CYCLES_P - 1));
  wire  [11:0] ms_inc  = ms_ff + 12'h001;
  wire         hit     = tick && !violation_ff && (ms_inc >= limit_ff);

  assign mon.violation = violation_ff;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      limit_ff <= LIMIT_DEFAULT_MS;
    end else if (mon.load) begin
      limit_ff <= mon.new_limit;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_ff <= 32'h0;
      ms_ff   <= 12'h000;
    end else if (mon.restart) begin
      tick_ff <= 32'h0;
      ms_ff   <= 12'h000;
    end else begin
      tick_ff <= tick ? 32'h0 : tick_ff + 32'h1;
      if (tick && !violation_ff) begin
        ms_ff <= ms_inc;
      end
    end
  end

  // set wins over a restart in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      violation_ff <= 1'b0;
    end else if (hit) begin
      violation_ff <= 1'b1;
    end else if (mon.restart) begin
      violation_ff <= 1'b0;
    end
  end

endmodule

//--- design/sfu_mon_if.sv
/*
  Link between the call sequencer and the cycle-time monitor.
  Assumes both ends run on ref_clk.
*/
`timescale 1ns/10ps
interface sfu_mon_if;
  logic        restart;
  logic        load;
  logic [11:0] new_limit;
  logic        violation;

  modport ctrl (output restart, output load, output new_limit, input violation);
  modport mon  (input restart, input load, input new_limit, output violation);
endinterface

//--- design/sfu_pkg.sv
/*
  Constants shared by the special function unit: call numbers, cycle monitor
  figures and the layout of a shift-register record in data-block memory.
  Assumes a 20 MHz ref_clk; nothing else.
*/
package sfu_pkg;

  // call numbers
  localparam logic [7:0]  FN_FIRST         = 8'h28; // 40, lowest reserved number
  localparam logic [7:0]  FN_SIGN_EXT      = 8'hdc; // 220
  localparam logic [7:0]  FN_SET_CYCLE     = 8'hdd; // 221
  localparam logic [7:0]  FN_RETRIGGER     = 8'hde; // 222
  localparam logic [7:0]  FN_SYS_BYTE      = 8'he2; // 226
  localparam logic [7:0]  FN_CHECKSUM      = 8'he3; // 227
  localparam logic [7:0]  FN_SHIFT         = 8'hf1; // 241

  // cycle monitor
  localparam logic [11:0] LIMIT_DEFAULT_MS = 12'h096; // 150 ms
  localparam logic [31:0] LIMIT_MIN_MS     = 32'h0000_0001; // 1 ms
  localparam logic [31:0] LIMIT_MAX_MS     = 32'h0000_0fa0; // 4000 ms
  localparam int          CLK_HZ           = 20000000;
  localparam int          TICK_MS          = 1;
  localparam int          TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;

  // shift registers
  localparam logic [15:0] SR_FIRST         = 16'h00c0; // 192
  localparam logic [15:0] SR_LAST          = 16'h00ff; // 255
  localparam logic [7:0]  TAPS_MAX         = 8'h06;
  localparam logic [15:0] SR_STRIDE        = 16'h0110; // bytes per record
  localparam logic [3:0]  HDR_LEN          = 4'h0; // length minus one
  localparam logic [3:0]  HDR_FLAG         = 4'h1; // first flag byte
  localparam logic [3:0]  HDR_TAPS         = 4'h2; // tap count incl. base
  localparam logic [3:0]  HDR_GAP          = 4'h3; // gaps n2..n6 at 3..7
  localparam logic [3:0]  HDR_HEAD         = 4'h8; // physical slot of cell 1
  localparam logic [15:0] HDR_CELLS        = 16'h0009; // first cell byte

  // system program memory
  localparam int          SYS_DEPTH_DEFAULT = 65536;

endpackage

//--- design/sfu_top.sv
/*
  Special function unit: sequences numbered system calls from the user
  program (sign extension, cycle monitor control, system memory reads,
  circular byte shift registers). Assumes byte memories for system program,
  data blocks and flag bytes that return read data one cycle after the read
  strobe, and shift-register records already laid out in data-block memory.
*/
`timescale 1ns/10ps
module sfu_top
  import sfu_pkg::*;
#(
  parameter int TICK_CYCLES_P = sfu_pkg::TICK_CYCLES,
  parameter int SYS_AW        = 16,
  parameter int SYS_DEPTH     = sfu_pkg::SYS_DEPTH_DEFAULT
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              call_valid,
  input  wire logic [7:0]        call_num,
  input  wire logic [31:0]       accu1_in,
  input  wire logic [31:0]       accu2_in,
  output logic                   call_ready,
  output logic                   call_done,
  output logic [31:0]            accu1_out,
  output logic [31:0]            accu2_out,
  output logic                   special_function_fault,
  input  wire logic              cycle_restart,
  output logic                   cycle_time_violation,
  output logic                   sys_rd,
  output logic [SYS_AW-1:0]      sys_addr,
  input  wire logic [7:0]        sys_rdata,
  output logic                   db_rd,
  output logic                   db_wr,
  output logic [15:0]            db_addr,
  output logic [7:0]             db_wdata,
  input  wire logic [7:0]        db_rdata,
  output logic                   flag_rd,
  output logic                   flag_wr,
  output logic [7:0]             flag_addr,
  output logic [7:0]             flag_wdata,
  input  wire logic [7:0]        flag_rdata
);
  import sfu_pkg::*;

  typedef enum logic [3:0] {
    ST_SCAN   = 4'h0,
    ST_IDLE   = 4'h1,
    ST_SYS_A  = 4'h2,
    ST_SYS_B  = 4'h3,
    ST_HDR_A  = 4'h4,
    ST_HDR_B  = 4'h5,
    ST_CHECK  = 4'h6,
    ST_PUSH_A = 4'h7,
    ST_PUSH_B = 4'h8,
    ST_HEAD   = 4'h9,
    ST_PULL_A = 4'ha,
    ST_PULL_B = 4'hb
  } sfu_state_t;

  sfu_state_t      state_ff;
  sfu_state_t      nxt_state;
  logic [31:0]     accu1_ff;
  logic [31:0]     nxt_accu1;
  logic [31:0]     accu2_ff;
  logic [31:0]     nxt_accu2;
  logic            done_ff;
  logic            nxt_done;
  logic            fault_ff;
  logic            nxt_fault;
  logic [3:0]      idx_ff;
  logic [3:0]      nxt_idx;
  logic [15:0]     base_ff;
  logic [7:0]      len_m1_ff;
  logic [7:0]      flag_base_ff;
  logic [7:0]      taps_ff;
  logic [7:0]      gap_ff [1:5];
  logic [7:0]      head_ff;
  logic [15:0]     sum_ff;
  logic [SYS_AW:0] scan_addr_ff;
  logic            scan_pend_ff;

  sfu_mon_if mon_link ();

  sfu_cycle_mon #(
    .TICK_CYCLES_P (TICK_CYCLES_P)
  ) u_mon (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .mon     (mon_link)
  );

  // call decode
  wire         take        = call_valid && (state_ff == ST_IDLE);
  wire         is_special  = (call_num >= FN_FIRST);
  wire         cyc_in_rng  = (accu1_in >= LIMIT_MIN_MS) && (accu1_in <= LIMIT_MAX_MS);
  wire  [15:0] sr_num      = accu1_in[15:0];
  wire         sr_in_rng   = (sr_num >= SR_FIRST) && (sr_num <= SR_LAST);
  wire  [15:0] sr_base     = 16'(32'(sr_num - SR_FIRST) * 32'(SR_STRIDE));
  wire         scan_issued = (scan_addr_ff == (SYS_AW + 1)'(SYS_DEPTH));

  // tap position inside the ring
  wire  [7:0]  tap_gap     = (idx_ff == 4'h0) ? 8'h00 : gap_ff[idx_ff[2:0]];
  wire  [8:0]  phys_sum    = {1'b0, head_ff} + {1'b0, tap_gap};
  wire  [8:0]  ring_len    = {1'b0, len_m1_ff} + 9'h001;
  wire  [8:0]  phys        = (phys_sum > {1'b0, len_m1_ff}) ? phys_sum - ring_len : phys_sum;
  wire  [15:0] cell_addr   = base_ff + HDR_CELLS + {7'h00, phys};
  wire  [15:0] hdr_addr    = base_ff + {12'h000, idx_ff};
  wire  [7:0]  head_next   = (head_ff == 8'h00) ? len_m1_ff : head_ff - 8'h01;
  wire         last_tap    = ({4'h0, idx_ff} + 8'h01) == taps_ff;
  wire         cfg_bad     = (len_m1_ff == 8'h00) || (taps_ff == 8'h00) ||
                             (taps_ff > TAPS_MAX);

  // memory strobes
  assign sys_rd     = ((state_ff == ST_SCAN) && !scan_issued) || (state_ff == ST_SYS_A);
  assign sys_addr   = (state_ff == ST_SCAN) ? scan_addr_ff[SYS_AW-1:0]
                                            : accu2_ff[SYS_AW-1:0];
  assign db_rd      = (state_ff == ST_HDR_A) || (state_ff == ST_PULL_A);
  assign db_wr      = (state_ff == ST_PUSH_B) || (state_ff == ST_HEAD);
  assign db_addr    = (state_ff == ST_HDR_A) ? hdr_addr :
                      (state_ff == ST_HEAD)  ? base_ff + {12'h000, HDR_HEAD} : cell_addr;
  assign db_wdata   = (state_ff == ST_HEAD) ? head_next : flag_rdata;
  assign flag_rd    = (state_ff == ST_PUSH_A);
  assign flag_wr    = (state_ff == ST_PULL_B);
  assign flag_addr  = flag_base_ff + {4'h0, idx_ff};
  assign flag_wdata = db_rdata;

  // cycle monitor control
  wire         set_cycle = take && (call_num == FN_SET_CYCLE) && cyc_in_rng;
  assign mon_link.load      = set_cycle;
  assign mon_link.new_limit = accu1_in[11:0];
  assign mon_link.restart   = cycle_restart || set_cycle ||
                              (take && (call_num == FN_RETRIGGER));
  assign cycle_time_violation = mon_link.violation;

  assign call_ready             = (state_ff == ST_IDLE);
  assign call_done              = done_ff;
  assign accu1_out              = accu1_ff;
  assign accu2_out              = accu2_ff;
  assign special_function_fault = fault_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_accu1 = accu1_ff;
    nxt_accu2 = accu2_ff;
    nxt_idx   = idx_ff;
    nxt_done  = 1'b0;
    nxt_fault = 1'b0;
    unique case (state_ff)
      ST_SCAN: begin
        if (scan_issued && !scan_pend_ff) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (take) begin
          nxt_accu1 = accu1_in;
          nxt_accu2 = accu2_in;
          nxt_done  = 1'b1;
          if (!is_special) begin
            nxt_fault = 1'b1;
          end else begin
            unique case (call_num)
              FN_SIGN_EXT: begin
                nxt_accu1 = {{16{accu1_in[15]}}, accu1_in[15:0]};
              end
              FN_SET_CYCLE: begin
                nxt_fault = !cyc_in_rng;
              end
              FN_RETRIGGER: begin
                nxt_fault = 1'b0;
              end
              FN_SYS_BYTE: begin
                nxt_done  = 1'b0;
                nxt_state = ST_SYS_A;
              end
              FN_CHECKSUM: begin
                nxt_accu2 = accu1_in;
                nxt_accu1 = {16'h0000, sum_ff};
              end
              FN_SHIFT: begin
                if (sr_in_rng) begin
                  nxt_done  = 1'b0;
                  nxt_idx   = 4'h0;
                  nxt_state = ST_HDR_A;
                end else begin
                  nxt_fault = 1'b1;
                end
              end
              default: begin
                nxt_fault = 1'b1;
              end
            endcase
          end
        end
      end
      ST_SYS_A: begin
        nxt_state = ST_SYS_B;
      end
      ST_SYS_B: begin
        nxt_accu2 = accu1_ff;
        nxt_accu1 = {24'h000000, sys_rdata};
        nxt_done  = 1'b1;
        nxt_state = ST_IDLE;
      end
      ST_HDR_A: begin
        nxt_state = ST_HDR_B;
      end
      ST_HDR_B: begin
        nxt_idx   = (idx_ff == HDR_HEAD) ? 4'h0 : idx_ff + 4'h1;
        nxt_state = (idx_ff == HDR_HEAD) ? ST_CHECK : ST_HDR_A;
      end
      ST_CHECK: begin
        if (cfg_bad) begin
          nxt_done  = 1'b1;
          nxt_fault = 1'b1;
          nxt_state = ST_IDLE;
        end else begin
          nxt_state = ST_PUSH_A;
        end
      end
      ST_PUSH_A: begin
        nxt_state = ST_PUSH_B;
      end
      ST_PUSH_B: begin
        nxt_idx   = last_tap ? 4'h0 : idx_ff + 4'h1;
        nxt_state = last_tap ? ST_HEAD : ST_PUSH_A;
      end
      ST_HEAD: begin
        nxt_state = ST_PULL_A;
      end
      ST_PULL_A: begin
        nxt_state = ST_PULL_B;
      end
      ST_PULL_B: begin
        nxt_idx   = last_tap ? 4'h0 : idx_ff + 4'h1;
        nxt_state = last_tap ? ST_IDLE : ST_PULL_A;
        nxt_done  = last_tap;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_SCAN;
      accu1_ff <= 32'h0;
      accu2_ff <= 32'h0;
      idx_ff   <= 4'h0;
      done_ff  <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      accu1_ff <= nxt_accu1;
      accu2_ff <= nxt_accu2;
      idx_ff   <= nxt_idx;
      done_ff  <= nxt_done;
      fault_ff <= nxt_fault;
    end
  end

  // checksum scan of the whole system memory after reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scan_addr_ff <= '0;
      scan_pend_ff <= 1'b0;
      sum_ff       <= 16'h0000;
    end else if (state_ff == ST_SCAN) begin
      scan_pend_ff <= !scan_issued;
      if (!scan_issued) begin
        scan_addr_ff <= scan_addr_ff + (SYS_AW + 1)'(1);
      end
      if (scan_pend_ff) begin
        sum_ff <= sum_ff + {8'h00, sys_rdata};
      end
    end
  end

  // record header capture
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      base_ff      <= 16'h0000;
      len_m1_ff    <= 8'h00;
      flag_base_ff <= 8'h00;
      taps_ff      <= 8'h00;
      head_ff      <= 8'h00;
      for (int i = 1; i <= 5; i++) begin
        gap_ff[i] <= 8'h00;
      end
    end else begin
      if (take) begin
        base_ff <= sr_base;
      end
      if (state_ff == ST_HDR_B) begin
        unique case (idx_ff)
          HDR_LEN:  len_m1_ff    <= db_rdata;
          HDR_FLAG: flag_base_ff <= db_rdata;
          HDR_TAPS: taps_ff      <= db_rdata;
          HDR_HEAD: head_ff      <= db_rdata;
          default:  gap_ff[idx_ff[2:0] - 3'h2] <= db_rdata;
        endcase
      end
      if (state_ff == ST_HEAD) begin
        head_ff <= head_next;
      end
    end
  end

endmodule

//--- test/sfu_mem_model.sv
/*
  Byte memories at the far side: system program, data blocks, flag bytes.
  Assumes one-cycle read latency; the bench preloads the arrays.
*/
`timescale 1ns/10ps
module sfu_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        sys_rd,
  input  wire logic [15:0] sys_addr,
  output logic      [7:0]  sys_rdata,
  input  wire logic        db_rd,
  input  wire logic        db_wr,
  input  wire logic [15:0] db_addr,
  input  wire logic [7:0]  db_wdata,
  output logic      [7:0]  db_rdata,
  input  wire logic        flag_rd,
  input  wire logic        flag_wr,
  input  wire logic [7:0]  flag_addr,
  input  wire logic [7:0]  flag_wdata,
  output logic      [7:0]  flag_rdata
);
  logic [7:0] sys_mem  [16];
  logic [7:0] db_mem   [1024];
  logic [7:0] flag_mem [256];
  initial begin
    sys_rdata = 8'h00;
    db_rdata = 8'h00;
    flag_rdata = 8'h00;
    foreach (db_mem[i]) db_mem[i] = 8'h00;
    foreach (flag_mem[i]) flag_mem[i] = 8'h00;
  end
  // unread lines flip so stale data is never mistaken for an answer
  always @(posedge ref_clk) begin
    sys_rdata <= sys_rd ? sys_mem[sys_addr[3:0]] : ~sys_rdata;
    db_rdata <= db_rd ? db_mem[db_addr[9:0]] : ~db_rdata;
    flag_rdata <= flag_rd ? flag_mem[flag_addr] : ~flag_rdata;
    if (db_wr) db_mem[db_addr[9:0]] <= db_wdata;
    if (flag_wr) flag_mem[flag_addr] <= flag_wdata;
  end
endmodule

//--- test/sfu_top_sva.sv
/*
  Port assertions for the special function unit.
  Assumes a bind onto sfu_top, single clock ref_clk.
*/
`timescale 1ns/10ps
module sfu_top_sva #(
  parameter int SYS_AW = 16
) (
  input wire logic              ref_clk,
  input wire logic              reset_n,
  input wire logic              call_valid,
  input wire logic [7:0]        call_num,
  input wire logic [31:0]       accu1_in,
  input wire logic [31:0]       accu2_in,
  input wire logic              call_ready,
  input wire logic              call_done,
  input wire logic [31:0]       accu1_out,
  input wire logic [31:0]       accu2_out,
  input wire logic              special_function_fault,
  input wire logic              cycle_restart,
  input wire logic              cycle_time_violation,
  input wire logic              sys_rd,
  input wire logic [SYS_AW-1:0] sys_addr
);
  import sfu_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_take(logic [7:0] n);
    call_valid && call_ready && call_num == n;
  endsequence
  sequence s_ok;
    call_done && !special_function_fault;
  endsequence
  sequence s_sys_read;
    sys_rd && sys_addr == $past(accu2_in[SYS_AW-1:0]) ##2 s_ok;
  endsequence
  a_fault_with_done: assert property (special_function_fault |-> call_done)
    else $error("fault without done");
  a_low_number: assert property (call_valid && call_ready && call_num < FN_FIRST
    |=> call_done && special_function_fault) else $error("low number not faulted");
  a_sign_fill: assert property (s_take(FN_SIGN_EXT) |=> s_ok ##0
    accu1_out == {{16{$past(accu1_in[15])}}, $past(accu1_in[15:0])}) else $error("sign fill");
  a_limit_bad: assert property (s_take(FN_SET_CYCLE) ##0
    (accu1_in < LIMIT_MIN_MS || accu1_in > LIMIT_MAX_MS) |=> call_done && special_function_fault)
    else $error("bad limit taken");
  a_limit_good: assert property (s_take(FN_SET_CYCLE) ##0
    (accu1_in >= LIMIT_MIN_MS && accu1_in <= LIMIT_MAX_MS) |=> s_ok) else $error("limit refused");
  a_retrigger_clear: assert property (s_take(FN_RETRIGGER) |=> s_ok ##[0:2] !cycle_time_violation)
    else $error("retrigger kept violation");
  a_sys_byte: assert property (s_take(FN_SYS_BYTE) |=> s_sys_read ##0 accu1_out[31:8] == 24'h0
    && accu2_out == $past(accu1_in, 3)) else $error("system byte read");
  a_checksum_read: assert property (s_take(FN_CHECKSUM) |=> s_ok ##0 accu1_out[31:16] == 16'h0
    && accu2_out == $past(accu1_in)) else $error("checksum read");
  a_shift_number: assert property (s_take(FN_SHIFT) ##0 accu1_in[15:0] < SR_FIRST
    |=> call_done && special_function_fault) else $error("bad register number");
  a_restart_clear: assert property (cycle_restart ##1 !cycle_restart |-> ##[0:2] !cycle_time_violation)
    else $error("restart kept violation");
endmodule
bind sfu_top sfu_top_sva #(.SYS_AW(SYS_AW)) u_sva (.*);

//--- test/special_function_unit_tb.sv
/*
  Self-checking bench for the special function unit.
  Assumes sfu_mem_model as the byte memories, preloaded directly.
*/
`timescale 1ns/10ps
module special_function_unit_tb;
  import sfu_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        call_valid = 1'b0;
  logic [7:0]  call_num = 8'h00;
  logic [31:0] accu1_in = 32'h0;
  logic [31:0] accu2_in = 32'h0;
  logic        cycle_restart = 1'b0;
  logic        call_ready, call_done, special_function_fault, cycle_time_violation;
  logic        sys_rd, db_rd, db_wr, flag_rd, flag_wr, flt;
  logic [15:0] sys_addr, db_addr;
  logic [7:0]  sys_rdata, db_wdata, db_rdata, flag_addr, flag_wdata, flag_rdata;
  logic [31:0] accu1_out, accu2_out, r1, r2;
  int          lat, fail_count = 0, checked = 0;

  always #25 ref_clk = ~ref_clk;
  sfu_top #(.TICK_CYCLES_P(10), .SYS_DEPTH(16)) dut (.*);
  sfu_mem_model u_mem (.*);

  function automatic logic [7:0] sys_byte(input int a);
    return 8'(a * 37 + 90);
  endfunction
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_call(input logic [7:0] n, input logic [31:0] a1, input logic [31:0] a2);
    @(posedge ref_clk);
    #1;
    call_valid = 1'b1;
    call_num = n;
    accu1_in = a1;
    accu2_in = a2;
    while (call_ready !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    #1;
    call_valid = 1'b0;
    lat = 1;
    while (call_done !== 1'b1 && lat < 80) begin
      @(posedge ref_clk);
      #1;
      lat++;
    end
    flt = special_function_fault;
    r1 = accu1_out;
    r2 = accu2_out;
  endtask
  task automatic wait_viol;
    for (int k = 0; k < 20 && cycle_time_violation !== 1'b1; k++) @(posedge ref_clk);
    #1;
    chk("violation", 32'h1, {31'h0, cycle_time_violation});
  endtask

  task automatic t_misc;
    logic [7:0] nums [5] = '{8'h00, 8'h27, 8'h28, 8'hdf, 8'hf0};
    do_call(FN_SIGN_EXT, 32'h1234_8001, 32'h5555_aaaa);
    chk("ext neg", 32'hffff_8001, r1);
    chk("ext accu2", 32'h5555_aaaa, r2);
    chk("ext lat", 32'h1, 32'(lat));
    chk("ext fault", 32'h0, {31'h0, flt});
    do_call(FN_SIGN_EXT, 32'habcd_7fff, 32'h0);
    chk("ext pos", 32'h0000_7fff, r1);
    foreach (nums[i]) begin
      do_call(nums[i], 32'h0, 32'h0);
      chk("unknown fault", 32'h1, {31'h0, flt});
    end
    $display("t_misc done");
  endtask
  task automatic t_sys;
    logic [15:0] sum = 16'h0;
    for (int a = 0; a < 16; a += 5) begin
      do_call(FN_SYS_BYTE, 32'hdead_beef, 32'(a));
      chk("sys byte", {24'h0, sys_byte(a)}, r1);
      chk("sys accu2", 32'hdead_beef, r2);
      chk("sys lat", 32'h3, 32'(lat));
    end
    for (int a = 0; a < 16; a++) sum += {8'h0, sys_byte(a)};
    do_call(FN_CHECKSUM, 32'h0bad_f00d, 32'h0);
    chk("checksum", {16'h0, sum}, r1);
    chk("sum accu2", 32'h0bad_f00d, r2);
    $display("t_sys done");
  endtask
  task automatic t_cycle;
    logic [31:0] bad [3] = '{32'h0, 32'hfa1, 32'h1_0003};
    foreach (bad[i]) begin
      do_call(FN_SET_CYCLE, bad[i], 32'h0);
      chk("limit refused", 32'h1, {31'h0, flt});
    end
    do_call(FN_SET_CYCLE, 32'h3, 32'h0);
    chk("limit taken", 32'h0, {31'h0, flt});
    repeat (24) @(posedge ref_clk);
    #1;
    chk("early viol", 32'h0, {31'h0, cycle_time_violation});
    wait_viol;
    cycle_restart = 1'b1;
    @(posedge ref_clk);
    #1;
    cycle_restart = 1'b0;
    repeat (20) @(posedge ref_clk);
    #1;
    chk("restart clear", 32'h0, {31'h0, cycle_time_violation});
    do_call(FN_RETRIGGER, 32'h0, 32'h0);
    repeat (24) @(posedge ref_clk);
    #1;
    chk("retrigger", 32'h0, {31'h0, cycle_time_violation});
    wait_viol;
    do_call(FN_SET_CYCLE, 32'hfa0, 32'h0);
    chk("limit max", 32'h0, {31'h0, flt});
    $display("t_cycle done");
  endtask
  task automatic t_shift;
    logic [7:0] hdr [9] = '{8'h03, 8'h10, 8'h02, 8'h02, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
    logic [31:0] badn [3] = '{32'hbf, 32'hc1, 32'hc2};
    foreach (hdr[i]) u_mem.db_mem[i] = hdr[i];
    for (int c = 0; c < 4; c++) u_mem.db_mem[9+c] = 8'(c + 1);
    u_mem.db_mem[544] = 8'h03;
    u_mem.db_mem[546] = 8'h07;
    u_mem.flag_mem[16] = 8'haa;
    u_mem.flag_mem[17] = 8'hbb;
    do_call(FN_SHIFT, 32'hc0, 32'h0);
    chk("shift fault", 32'h0, {31'h0, flt});
    chk("shift lat", 32'd29, 32'(lat));
    chk("base tap", 32'h04, {24'h0, u_mem.flag_mem[16]});
    chk("tap two", 32'h02, {24'h0, u_mem.flag_mem[17]});
    do_call(FN_SHIFT, 32'hc0, 32'h0);
    chk("base wrap", 32'hbb, {24'h0, u_mem.flag_mem[16]});
    chk("tap two 2", 32'haa, {24'h0, u_mem.flag_mem[17]});
    foreach (badn[i]) begin
      do_call(FN_SHIFT, badn[i], 32'h0);
      chk("shift refused", 32'h1, {31'h0, flt});
    end
    $display("t_shift done");
  endtask

  initial begin
    foreach (u_mem.sys_mem[i]) u_mem.sys_mem[i] = sys_byte(i);
    repeat (6) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    for (int k = 0; k < 40 && call_ready !== 1'b1; k++) @(posedge ref_clk);
    t_misc;
    t_sys;
    t_cycle;
    t_shift;
    stop_test;
  end
  initial begin
    #(5000 * 50);
    fail_count++;
    stop_test;
  end
endmodule
